// *** fpc_regs.svh ***
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
`define FPC_NUM_SLOTS 14
`define FPC_SLOT_MIN 4'h1
`define FPC_SLOT_MAX 4'he
`define FPC_FN_CLEAR 5'h01
`define FPC_FN_RSV_LO 5'h02
`define FPC_FN_RSV_HI 5'h08
`define FPC_FN_LOCK 5'h09
`define FPC_FN_SETPW 5'h0a
`define FPC_FN_ALIGN_LO 5'h0b
`define FPC_FN_ALIGN_HI 5'h0e
`define FPC_FN_FWUPD 5'h0f
`define FPC_FN_FACTORY 5'h10
`define FPC_PW_DEFAULT 16'h0000
`define FPC_FLASH_MS 250
`define FPC_CLK_MHZ 50
`define FPC_FLASH_CYC (`FPC_FLASH_MS * 1000 * `FPC_CLK_MHZ)
`define FPC_SEQ_MS 500
`define FPC_SEQ_CYC (`FPC_SEQ_MS * 1000 * `FPC_CLK_MHZ)
`endif

// *** fpc_pkg.sv ***
package fpc_pkg;
  typedef enum logic [2:0] {
    FPC_TYPE_NONE,
    FPC_TYPE_RS232,
    FPC_TYPE_MIDI_IN,
    FPC_TYPE_MIDI_OUT,
    FPC_TYPE_GPIO_IN,
    FPC_TYPE_GPIO_OUT
  } fpc_type_e;
  typedef logic [3:0] fpc_slot_t;
  typedef logic [3:0] fpc_digit_t;
  function automatic logic fpc_is_input(input fpc_type_e t);
    fpc_is_input = (t == FPC_TYPE_RS232) || (t == FPC_TYPE_MIDI_IN) || (t == FPC_TYPE_GPIO_IN);
  endfunction : fpc_is_input
endpackage : fpc_pkg

// *** fpc_pw_if.sv ***
`timescale 1ns/10ps
interface fpc_pw_if;
  logic clear;
  logic push;
  fpc_pkg::fpc_digit_t digit;
  logic store;
  logic restore;
  logic match;
  logic [15:0] stored;
  modport ctl(output clear, output push, output digit, output store, output restore,
              input match, input stored);
  modport pw(input clear, input push, input digit, input store, input restore,
             output match, output stored);
endinterface : fpc_pw_if

// *** fpc_password.sv ***
`timescale 1ns/10ps
`include "fpc_regs.svh"
module fpc_password (
  input wire logic i_clk,
  input wire logic i_rst_b,
  fpc_pw_if.pw pw
);
  logic [15:0] entry_ff;
  logic [15:0] stored_ff;
  logic [2:0] cnt_ff;
  // Only the last four digits are kept; older presses shift out.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      entry_ff <= 16'h0000;
      cnt_ff <= 3'h0;
    end else if (pw.clear) begin
      entry_ff <= 16'h0000;
      cnt_ff <= 3'h0;
    end else if (pw.push) begin
      entry_ff <= {entry_ff[11:0], pw.digit};
      if (cnt_ff != 3'h4) begin
        cnt_ff <= cnt_ff + 3'h1;
      end
    end
  end
  // Digits are stored as button number minus one, so the default is button one four times.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stored_ff <= `FPC_PW_DEFAULT;
    end else if (pw.restore) begin
      stored_ff <= `FPC_PW_DEFAULT;
    end else if (pw.store && cnt_ff == 3'h4) begin
      stored_ff <= entry_ff;
    end
  end
  assign pw.match = (cnt_ff == 3'h4) && (entry_ff == stored_ff);
  assign pw.stored = stored_ff;
endmodule : fpc_password

// *** fpc_panel.sv ***
`timescale 1ns/10ps
`include "fpc_regs.svh"
module fpc_panel #(
  parameter int NUM_SLOTS = `FPC_NUM_SLOTS,
  parameter int FLASH_CYC = `FPC_FLASH_CYC,
  parameter int SEQ_CYC = `FPC_SEQ_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_btn_inc,
  input wire logic i_btn_dec,
  input wire logic i_btn_type,
  input wire logic i_btn_enter,
  input wire logic i_btn_cancel,
  input wire logic i_btn_function,
  input wire logic i_btn_other,
  input wire logic i_chan_press,
  input wire logic [3:0] i_chan_num,
  input wire logic i_is_controller,
  input wire logic i_managed,
  input wire logic i_edit_locked,
  input wire logic [NUM_SLOTS-1:0] i_net_in_use,
  input wire logic [3*NUM_SLOTS-1:0] i_net_type,
  output logic [3:0] o_slot_disp,
  output logic o_in_use_led,
  output logic [4:0] o_type_led,
  output logic o_enter_cancel_led,
  output logic o_function_led,
  output logic o_type_list_flash,
  output logic o_chan_flash,
  output logic o_warn_pattern,
  output logic o_meter_red_seq,
  output logic o_meter_green_seq,
  output logic o_lock_led,
  output logic o_net_locked,
  output logic o_assign_req,
  output logic o_release_req,
  output logic [3:0] o_req_slot,
  output logic [2:0] o_req_type,
  output logic o_clear_req,
  output logic o_fn_req,
  output logic [4:0] o_fn_num,
  output logic o_fn_refused
);
  typedef enum logic [2:0] {
    FPC_IDLE,
    FPC_TYPE_SEL,
    FPC_FN_WAIT,
    FPC_FN_ARMED,
    FPC_PW_ENTRY
  } fpc_state_e;
  fpc_state_e state_ff;
  fpc_pkg::fpc_slot_t slot_ff;
  fpc_pkg::fpc_type_e sel_ff;
  logic [4:0] fn_ff;
  logic locked_ff;
  logic flash_ff;
  logic [31:0] flash_cnt_ff;
  logic [31:0] seq_cnt_ff;
  logic red_ff;
  logic green_ff;
  logic [5:0] evt_ff;
  logic [3:0] req_slot_ff;
  logic [2:0] req_type_ff;
  logic [4:0] fn_num_ff;
  logic [NUM_SLOTS-1:0] own_in_ff;
  fpc_pw_if pwb ();
  fpc_password u_pw (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .pw(pwb.pw)
  );
  logic [3:0] idx;
  logic slot_used;
  fpc_pkg::fpc_type_e slot_type;
  logic panel_frozen;
  logic abort_fn;
  logic [4:0] chan_fn;
  fpc_pkg::fpc_type_e nxt_sel;
  assign idx = slot_ff - 4'h1;
  assign slot_used = i_net_in_use[idx];
  assign slot_type = fpc_pkg::fpc_type_e'(i_net_type[3*idx +: 3]);
  assign panel_frozen = i_edit_locked || i_managed || locked_ff;
  assign chan_fn = {1'b0, i_chan_num} + 5'h01;
  assign abort_fn = i_btn_cancel || i_btn_other || i_btn_inc || i_btn_dec || i_btn_type;
  // Selector cycles through none and the five types; a held input slot only offers its own type.
  always_comb begin
    nxt_sel = fpc_pkg::FPC_TYPE_NONE;
    if (slot_used && fpc_pkg::fpc_is_input(slot_type) && !own_in_ff[idx]) begin
      nxt_sel = (sel_ff == fpc_pkg::FPC_TYPE_NONE) ? slot_type : fpc_pkg::FPC_TYPE_NONE;
    end else if (slot_used && own_in_ff[idx]) begin
      nxt_sel = (sel_ff == fpc_pkg::FPC_TYPE_NONE) ? slot_type : fpc_pkg::FPC_TYPE_NONE;
    end else begin
      unique case (sel_ff)
        fpc_pkg::FPC_TYPE_NONE: nxt_sel = fpc_pkg::FPC_TYPE_RS232;
        fpc_pkg::FPC_TYPE_RS232: nxt_sel = fpc_pkg::FPC_TYPE_MIDI_IN;
        fpc_pkg::FPC_TYPE_MIDI_IN: nxt_sel = fpc_pkg::FPC_TYPE_MIDI_OUT;
        fpc_pkg::FPC_TYPE_MIDI_OUT: nxt_sel = fpc_pkg::FPC_TYPE_GPIO_IN;
        fpc_pkg::FPC_TYPE_GPIO_IN: nxt_sel = fpc_pkg::FPC_TYPE_GPIO_OUT;
        fpc_pkg::FPC_TYPE_GPIO_OUT: nxt_sel = fpc_pkg::FPC_TYPE_NONE;
        default: nxt_sel = fpc_pkg::FPC_TYPE_NONE;
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slot_ff <= `FPC_SLOT_MIN;
    end else if (i_btn_inc) begin
      // Stepping works in every state so the display never ignores a press; menus still abort.
      slot_ff <= (slot_ff == `FPC_SLOT_MAX) ? `FPC_SLOT_MIN : slot_ff + 4'h1;
    end else if (i_btn_dec) begin
      slot_ff <= (slot_ff == `FPC_SLOT_MIN) ? `FPC_SLOT_MAX : slot_ff - 4'h1;
    end
  end
  logic enter_fn_ok;
  always_comb begin
    enter_fn_ok = 1'b0;
    if (fn_ff == `FPC_FN_CLEAR) begin
      enter_fn_ok = !locked_ff && !i_managed && !i_edit_locked;
    end else if (fn_ff == `FPC_FN_LOCK) begin
      enter_fn_ok = i_is_controller && !locked_ff;
    end else if (fn_ff >= `FPC_FN_RSV_LO && fn_ff <= `FPC_FN_RSV_HI) begin
      enter_fn_ok = 1'b0;
    end else begin
      enter_fn_ok = 1'b1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= FPC_IDLE;
      sel_ff <= fpc_pkg::FPC_TYPE_NONE;
      fn_ff <= 5'h00;
    end else begin
      unique case (state_ff)
        FPC_IDLE: begin
          if (i_btn_function) begin
            state_ff <= FPC_FN_WAIT;
          end else if (i_btn_type && !panel_frozen) begin
            sel_ff <= nxt_sel;
            state_ff <= FPC_TYPE_SEL;
          end
        end
        FPC_TYPE_SEL: begin
          if (i_btn_type) begin
            sel_ff <= nxt_sel;
          end else if (i_btn_function) begin
            state_ff <= FPC_FN_WAIT;
            sel_ff <= fpc_pkg::FPC_TYPE_NONE;
          end else if (i_btn_enter || i_btn_cancel || i_btn_inc || i_btn_dec) begin
            state_ff <= FPC_IDLE;
            sel_ff <= fpc_pkg::FPC_TYPE_NONE;
          end
        end
        FPC_FN_WAIT: begin
          if (abort_fn || i_btn_function || i_btn_enter) begin
            state_ff <= FPC_IDLE;
          end else if (i_chan_press) begin
            fn_ff <= chan_fn;
            state_ff <= FPC_FN_ARMED;
          end
        end
        FPC_FN_ARMED: begin
          if (abort_fn || i_btn_function || i_chan_press) begin
            state_ff <= FPC_IDLE;
          end else if (i_btn_enter) begin
            state_ff <= (fn_ff == `FPC_FN_SETPW || (fn_ff == `FPC_FN_LOCK && locked_ff)) ?
                        FPC_PW_ENTRY : FPC_IDLE;
          end
        end
        FPC_PW_ENTRY: begin
          if (abort_fn || i_btn_enter || i_btn_function) begin
            state_ff <= FPC_IDLE;
          end
        end
      endcase
    end
  end
  // Keypad digits go to the password store; the shifter keeps only the newest four.
  assign pwb.clear = (state_ff == FPC_FN_ARMED) && i_btn_enter;
  assign pwb.push = (state_ff == FPC_PW_ENTRY) && i_chan_press;
  assign pwb.digit = i_chan_num;
  assign pwb.store = (state_ff == FPC_PW_ENTRY) && i_btn_enter && fn_ff == `FPC_FN_SETPW
                     && !locked_ff;
  assign pwb.restore = (state_ff == FPC_FN_ARMED) && i_btn_enter && fn_ff == `FPC_FN_FACTORY;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      locked_ff <= 1'b0;
    end else if (state_ff == FPC_FN_ARMED && i_btn_enter && fn_ff == `FPC_FN_LOCK
                 && enter_fn_ok) begin
      locked_ff <= 1'b1;
    end else if (state_ff == FPC_PW_ENTRY && i_btn_enter && fn_ff == `FPC_FN_LOCK
                 && pwb.match && i_is_controller) begin
      locked_ff <= 1'b0;
    end
  end
  // Local record of input slots this module claimed, so only it may release them.
  logic commit;
  assign commit = (state_ff == FPC_TYPE_SEL) && i_btn_enter;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      own_in_ff <= '0;
    end else if (pwb.restore || (state_ff == FPC_FN_ARMED && i_btn_enter
                 && fn_ff == `FPC_FN_CLEAR && enter_fn_ok)) begin
      own_in_ff <= '0;
    end else if (commit && sel_ff == fpc_pkg::FPC_TYPE_NONE && own_in_ff[idx]) begin
      own_in_ff[idx] <= 1'b0;
    end else if (commit && fpc_pkg::fpc_is_input(sel_ff) && !slot_used) begin
      own_in_ff[idx] <= 1'b1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      evt_ff <= 6'h00;
      req_slot_ff <= 4'h0;
      req_type_ff <= 3'h0;
      fn_num_ff <= 5'h00;
    end else begin
      evt_ff <= 6'h00;
      if (commit && sel_ff == fpc_pkg::FPC_TYPE_NONE && own_in_ff[idx]) begin
        evt_ff[1] <= 1'b1;
        req_slot_ff <= slot_ff;
      end else if (commit && sel_ff != fpc_pkg::FPC_TYPE_NONE &&
                   (!slot_used || !fpc_pkg::fpc_is_input(sel_ff))) begin
        evt_ff[0] <= 1'b1;
        req_slot_ff <= slot_ff;
        req_type_ff <= sel_ff;
      end
      if (state_ff == FPC_FN_ARMED && i_btn_enter) begin
        fn_num_ff <= fn_ff;
        if (!enter_fn_ok) begin
          evt_ff[3] <= 1'b1;
        end else if (fn_ff == `FPC_FN_CLEAR) begin
          evt_ff[2] <= 1'b1;
        end else if (fn_ff != `FPC_FN_LOCK && fn_ff != `FPC_FN_SETPW) begin
          evt_ff[4] <= 1'b1;
        end
      end
    end
  end
  // Slow blink and meter sequence timers share nothing so a lock animation survives menu exits.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flash_cnt_ff <= 32'h0;
      flash_ff <= 1'b0;
    end else if (flash_cnt_ff >= 32'(FLASH_CYC - 1)) begin
      flash_cnt_ff <= 32'h0;
      flash_ff <= ~flash_ff;
    end else begin
      flash_cnt_ff <= flash_cnt_ff + 32'h1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seq_cnt_ff <= 32'h0;
      red_ff <= 1'b0;
      green_ff <= 1'b0;
    end else if (state_ff == FPC_FN_ARMED && i_btn_enter && fn_ff == `FPC_FN_LOCK
                 && enter_fn_ok) begin
      seq_cnt_ff <= 32'(SEQ_CYC);
      red_ff <= 1'b1;
      green_ff <= 1'b0;
    end else if (state_ff == FPC_PW_ENTRY && i_btn_enter && fn_ff == `FPC_FN_LOCK
                 && pwb.match && i_is_controller) begin
      seq_cnt_ff <= 32'(SEQ_CYC);
      red_ff <= 1'b0;
      green_ff <= 1'b1;
    end else if (seq_cnt_ff != 32'h0) begin
      seq_cnt_ff <= seq_cnt_ff - 32'h1;
    end else begin
      red_ff <= 1'b0;
      green_ff <= 1'b0;
    end
  end
  always_comb begin
    o_type_led = 5'h00;
    unique case (sel_ff)
      fpc_pkg::FPC_TYPE_RS232: o_type_led = 5'h01;
      fpc_pkg::FPC_TYPE_MIDI_IN: o_type_led = 5'h02;
      fpc_pkg::FPC_TYPE_MIDI_OUT: o_type_led = 5'h04;
      fpc_pkg::FPC_TYPE_GPIO_IN: o_type_led = 5'h08;
      fpc_pkg::FPC_TYPE_GPIO_OUT: o_type_led = 5'h10;
      default: o_type_led = 5'h00;
    endcase
  end
  assign o_slot_disp = slot_ff;
  assign o_in_use_led = slot_used && fpc_pkg::fpc_is_input(slot_type);
  assign o_enter_cancel_led = flash_ff && state_ff != FPC_IDLE;
  assign o_function_led = (state_ff == FPC_FN_WAIT || state_ff == FPC_FN_ARMED
                           || state_ff == FPC_PW_ENTRY);
  assign o_type_list_flash = flash_ff && state_ff == FPC_FN_ARMED && fn_ff == `FPC_FN_CLEAR;
  assign o_chan_flash = flash_ff && state_ff == FPC_FN_ARMED && fn_ff == `FPC_FN_CLEAR;
  assign o_warn_pattern = flash_ff && state_ff == FPC_FN_ARMED && fn_ff == `FPC_FN_LOCK;
  assign o_meter_red_seq = red_ff;
  assign o_meter_green_seq = green_ff;
  assign o_lock_led = locked_ff;
  assign o_net_locked = locked_ff;
  assign o_assign_req = evt_ff[0];
  assign o_release_req = evt_ff[1];
  assign o_clear_req = evt_ff[2];
  assign o_fn_refused = evt_ff[3];
  assign o_fn_req = evt_ff[4];
  assign o_req_slot = req_slot_ff;
  assign o_req_type = req_type_ff;
  assign o_fn_num = fn_num_ff;
endmodule : fpc_panel

// *** fpc_panel_props.sv ***
`timescale 1ns/10ps
module fpc_panel_chk #(
  parameter int NUM_SLOTS = 14
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_btn_inc,
  input wire logic i_btn_dec,
  input wire logic i_btn_enter,
  input wire logic i_btn_cancel,
  input wire logic i_btn_function,
  input wire logic i_btn_other,
  input wire logic i_is_controller,
  input wire logic i_managed,
  input wire logic [NUM_SLOTS-1:0] i_net_in_use,
  input wire logic [3*NUM_SLOTS-1:0] i_net_type,
  input wire logic [3:0] o_slot_disp,
  input wire logic o_in_use_led,
  input wire logic [4:0] o_type_led,
  input wire logic o_function_led,
  input wire logic o_meter_red_seq,
  input wire logic o_lock_led,
  input wire logic o_net_locked,
  input wire logic o_assign_req,
  input wire logic o_clear_req
);
  logic [2:0] cur_type;
  logic held;
  assign cur_type = i_net_type[3*(o_slot_disp-1)+:3];
  assign held = i_net_in_use[o_slot_disp-1] && (cur_type inside {3'h1, 3'h2, 3'h4});
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  AST_DISP_RANGE: assert property (o_slot_disp >= 4'h1 && o_slot_disp <= 4'he)
    else $error("slot display out of range");
  AST_INC_WRAP: assert property (i_btn_inc && o_slot_disp == 4'he |=> o_slot_disp == 4'h1)
    else $error("slot display did not wrap up to one");
  AST_DEC_WRAP: assert property (i_btn_dec && o_slot_disp == 4'h1 |=> o_slot_disp == 4'he)
    else $error("slot display did not wrap down to fourteen");
  AST_IN_USE: assert property (o_in_use_led == held)
    else $error("in-use indicator disagrees with network report");
  AST_TYPE_ONEHOT: assert property ($onehot0(o_type_led))
    else $error("more than one type indicator lit");
  AST_FN_LED: assert property (i_btn_function && !o_function_led |=> o_function_led)
    else $error("function indicator did not light");
  AST_FN_ABORT: assert property (o_function_led && (i_btn_cancel || i_btn_other) |=> !o_function_led)
    else $error("function request not aborted");
  AST_CLR_CAUSE: assert property (o_clear_req |-> $past(i_btn_enter) && !$past(i_managed) && !o_net_locked)
    else $error("clear issued without a permitted enter");
  AST_CLR_PULSE: assert property (o_clear_req |=> !o_clear_req)
    else $error("clear request longer than one cycle");
  AST_ASSIGN_CAUSE: assert property (o_assign_req |-> $past(i_btn_enter) && !o_net_locked)
    else $error("assignment issued without enter or while locked");
  AST_LOCK_CTRL: assert property ($rose(o_net_locked) |-> $past(i_is_controller))
    else $error("network locked from a non-controller module");
  AST_RED_SEQ: assert property ($rose(o_net_locked) |-> ##[0:2] o_meter_red_seq)
    else $error("no red meter sequence after locking");
  AST_LOCK_LED: assert property (o_lock_led == o_net_locked)
    else $error("lock indicator disagrees with lock state");
  AST_UNLOCK_CAUSE: assert property ($fell(o_net_locked) |-> $past(i_btn_enter) && $past(i_is_controller))
    else $error("network unlocked without enter on the controller");
endmodule : fpc_panel_chk
bind fpc_panel fpc_panel_chk #(.NUM_SLOTS(NUM_SLOTS)) i_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_btn_inc(i_btn_inc), .i_btn_dec(i_btn_dec),
  .i_btn_enter(i_btn_enter), .i_btn_cancel(i_btn_cancel), .i_btn_function(i_btn_function),
  .i_btn_other(i_btn_other), .i_is_controller(i_is_controller), .i_managed(i_managed),
  .i_net_in_use(i_net_in_use), .i_net_type(i_net_type), .o_slot_disp(o_slot_disp),
  .o_in_use_led(o_in_use_led), .o_type_led(o_type_led), .o_function_led(o_function_led),
  .o_meter_red_seq(o_meter_red_seq), .o_lock_led(o_lock_led), .o_net_locked(o_net_locked),
  .o_assign_req(o_assign_req), .o_clear_req(o_clear_req)
);

// *** fpc_net_model.sv ***
`timescale 1ns/10ps
module fpc_net_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_assign,
  input wire logic i_release,
  input wire logic i_clear,
  input wire logic [3:0] i_slot,
  input wire logic [2:0] i_type,
  output logic [13:0] o_in_use,
  output logic [41:0] o_type
);
  logic [13:0] mine_ff;
  // Slot 10 is held as a MIDI input by another module, so a local clear must leave it.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_in_use <= 14'h0200;
      o_type <= 42'h10000000;
      mine_ff <= 14'h0000;
    end else if (i_clear) begin
      o_in_use <= o_in_use & ~mine_ff;
      mine_ff <= 14'h0000;
    end else if (i_release) begin
      o_in_use[i_slot-1] <= 1'b0;
      mine_ff[i_slot-1] <= 1'b0;
    end else if (i_assign) begin
      o_type[3*(i_slot-1)+:3] <= i_type;
      if (i_type inside {3'h1, 3'h2, 3'h4}) begin
        o_in_use[i_slot-1] <= 1'b1;
        mine_ff[i_slot-1] <= 1'b1;
      end
    end
  end
endmodule : fpc_net_model

// *** test_front_panel_cable_and_function_control.sv ***
`timescale 1ns/10ps
module test_front_panel_cable_and_function_control;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] btn = 8'h00;
  logic [3:0] cnum = 4'h0;
  logic ctrl = 1'b1;
  logic mgd = 1'b0;
  logic elk = 1'b0;
  logic [13:0] nuse;
  logic [41:0] ntyp;
  logic [3:0] disp, rslot;
  logic [4:0] tled, fnum;
  logic [2:0] rtyp;
  logic inuse, ecl, fled, lfl, cfl, warn, red, grn, lled, nlk, asg, rel, clr, freq, refd;
  logic [5:0] seen = 6'h00;
  int seed = 5;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  fpc_panel #(.FLASH_CYC(4), .SEQ_CYC(10)) i_dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_btn_inc(btn[0]), .i_btn_dec(btn[1]), .i_btn_type(btn[2]),
    .i_btn_enter(btn[3]), .i_btn_cancel(btn[4]), .i_btn_function(btn[5]),
    .i_btn_other(btn[6]), .i_chan_press(btn[7]), .i_chan_num(cnum), .i_is_controller(ctrl),
    .i_managed(mgd), .i_edit_locked(elk), .i_net_in_use(nuse), .i_net_type(ntyp),
    .o_slot_disp(disp), .o_in_use_led(inuse), .o_type_led(tled), .o_enter_cancel_led(ecl),
    .o_function_led(fled), .o_type_list_flash(lfl), .o_chan_flash(cfl), .o_warn_pattern(warn),
    .o_meter_red_seq(red), .o_meter_green_seq(grn), .o_lock_led(lled), .o_net_locked(nlk),
    .o_assign_req(asg), .o_release_req(rel), .o_req_slot(rslot), .o_req_type(rtyp),
    .o_clear_req(clr), .o_fn_req(freq), .o_fn_num(fnum), .o_fn_refused(refd)
  );
  fpc_net_model i_net (
    .i_clk(clk), .i_rst_b(rst_b), .i_assign(asg), .i_release(rel), .i_clear(clr),
    .i_slot(rslot), .i_type(rtyp), .o_in_use(nuse), .o_type(ntyp)
  );
  always #10 clk = ~clk;
  // Flashing outputs are sampled over a window, since any single cycle may fall dark.
  always @(posedge clk) seen <= seen | {grn, red, ecl, warn, cfl, lfl};
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic press(input int b, input int n = 0);
    @(posedge clk);
    btn <= 8'h01 << b;
    cnum <= n[3:0];
    tick;
    btn <= 8'h00;
  endtask : press
  task automatic go(input int s);
    while (disp !== s[3:0]) press(0);
  endtask : go
  task automatic fn(input int n);
    press(5);
    press(7, n - 1);
  endtask : fn
  task automatic unl(input logic [15:0] d);
    fn(9);
    press(3);
    for (int i = 0; i < 4; i++) press(7, d[4*i+:4]);
    press(3);
    tick;
  endtask : unl
  function automatic int step(input int s, input int dn);
    if (dn != 0)
      return (s == 1) ? 14 : s - 1;
    return (s == 14) ? 1 : s + 1;
  endfunction : step
  function automatic bit isin(input int t);
    return t == 1 || t == 2 || t == 4;
  endfunction : isin
  initial begin
    int e;
    int b;
    logic [15:0] npw;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk({disp, nlk}, 8'h02);
    e = 1;
    repeat (40) begin
      b = $random(seed) & 1;
      press(b);
      e = step(e, b);
      chk(disp, e);
    end
    for (int t = 1; t <= 5; t++) begin
      go(t + 2);
      repeat (t) press(2);
      chk(tled, 8'h01 << (t - 1));
      press(3);
      chk({asg, rslot, rtyp}, {1'b1, 4'(t + 2), 3'(t)});
      tick;
      chk(inuse, isin(t));
    end
    go(9);
    press(2);
    press(4);
    press(3);
    chk(asg, 0);
    go(10);
    chk(inuse, 1);
    press(2);
    chk(tled, 8'h02);
    press(4);
    go(3);
    b = 0;
    do begin
      press(2);
      b++;
    end while (tled !== 5'h00 && b < 7);
    press(3);
    chk({rel, rslot}, 5'h13);
    tick;
    chk(inuse, 0);
    mgd <= 1'b1;
    fn(1);
    press(3);
    chk({refd, clr}, 2'b10);
    mgd <= 1'b0;
    fn(1);
    seen = 6'h00;
    repeat (12) tick;
    chk(seen[3:0], 4'hb);
    press(4);
    chk({fled, clr}, 0);
    press(5);
    press(6);
    chk({fled, ecl}, 0);
    fn(1);
    chk(fled, 1);
    press(3);
    chk({clr, fnum}, 6'h21);
    tick;
    go(6);
    chk(inuse, 0);
    go(10);
    chk(inuse, 1);
    for (int n = 2; n <= 16; n++) begin
      if (n == 9 || n == 10)
        continue;
      fn(n);
      press(3);
      chk({refd, freq}, {n <= 8, n > 8});
      if (n > 8)
        chk(fnum, n);
    end
    ctrl <= 1'b0;
    fn(9);
    press(3);
    chk({refd, nlk}, 2'b10);
    ctrl <= 1'b1;
    fn(9);
    seen = 6'h00;
    repeat (12) tick;
    chk(seen[2], 1);
    press(3);
    repeat (4) tick;
    chk({nlk, lled, seen[4]}, 3'b111);
    go(8);
    press(2);
    press(3);
    chk({asg, rel}, 0);
    unl(16'h4321);
    chk(nlk, 1);
    seen = 6'h00;
    unl(16'h0000);
    repeat (4) tick;
    chk({nlk, lled, seen[5]}, 3'b001);
    elk <= 1'b1;
    go(11);
    press(2);
    press(3);
    chk(asg, 0);
    elk <= 1'b0;
    npw = 16'h0000;
    fn(10);
    press(3);
    repeat (5) begin
      b = $random(seed) & 15;
      press(7, b);
      npw = {b[3:0], npw[15:4]};
    end
    press(3);
    fn(9);
    press(3);
    tick;
    chk(nlk, 1);
    unl(npw);
    chk(nlk, 0);
    give_verdict();
  end
endmodule : test_front_panel_cable_and_function_control
